// *** eac_pkg.sv ***
// Package for the nonvolatile byte access controller
package eac_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          NV_DEPTH      = 128;
  localparam logic [1:0]  SEL_ADDRESS   = 2'h0;
  localparam logic [1:0]  SEL_DATA      = 2'h1;
  localparam logic [1:0]  SEL_CONTROL   = 2'h2;
  localparam int          BIT_ARM       = 2;
  localparam int          BIT_WSTROBE   = 1;
  localparam int          BIT_RSTROBE   = 0;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam int          ARM_CYCLES    = 4;
  localparam int          WSTALL_CYCLES = 2;
  localparam int          RSTALL_CYCLES = 4;
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          PROG_TIME_US  = 4000;
  // Worked in nanoseconds so the product stays inside a 32-bit int
  localparam int          PROG_CYCLES   = (PROG_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } eac_req_t;

  typedef enum logic [1:0] {
    EAC_IDLE = 2'b00,
    EAC_PROG = 2'b01
  } eac_state_t;
endpackage

// *** eac_top.sv ***
// Access controller for a 128-byte nonvolatile array behind three I/O registers
// How it works
// [R01] A 7-bit address picks one of 128 bytes numbered 0 to 127.
// [R02] Address bit 7 and control bits 7 to 3 always read as zero.
// [R03] The data register holds the byte to write, and after a read the byte fetched.
// [R04] The master write arm bit clears itself four cycles after software sets it.
// [R05] Setting the write strobe starts programming only while the arm bit is set.
// [R06] Software sets the arm bit only with a write that holds the write strobe at zero.
// [R07] Software waits for idle, loads address and data, arms, then strobes within four cycles.
// [R08] The write strobe clears when the self-timed programming interval ends.
// [R09] A write strobe stalls the CPU for two cycles.
// [R10] A read strobe fetches the byte into the data register and clears itself.
// [R11] A read strobe stalls the CPU for four cycles; set in the same write as an armed write strobe, it stalls for two.
// [R12] Writing address or data during programming aborts the write.
// [R13] Software checks the write strobe reads zero before a read.
// [R14] Software keeps interrupts off over the last four steps of a write.
// [R15] The write strobe reads one for as long as programming lasts.
`timescale 1ns/1ps
module eac_top
  import eac_pkg::*;
#(
  parameter int PROG_TIME = PROG_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire eac_req_t   req,
  output logic [7:0]      rdata,
  output logic            cpu_stall,
  output logic            write_strobe_busy
);
  logic [7:0]        mem [NV_DEPTH];
  logic [ADDR_W-1:0] byte_index_field_reg;
  logic [7:0]        byte_value_field_reg;
  logic              master_write_arm_reg;
  logic [2:0]        arm_cnt_reg;
  logic              read_strobe_reg;
  eac_state_t        state_reg;
  logic [31:0]       prog_cnt_reg;
  logic [2:0]        stall_cnt_reg;
  logic [7:0]        rdata_next;

  wire ctl_wr  = req.wr && req.sel == SEL_CONTROL;
  wire set_arm = ctl_wr && req.wdata[BIT_ARM] && !req.wdata[BIT_WSTROBE];
  wire wstart  = ctl_wr && req.wdata[BIT_WSTROBE] && master_write_arm_reg
                 && state_reg == EAC_IDLE;
  wire rstart  = ctl_wr && req.wdata[BIT_RSTROBE] && state_reg == EAC_IDLE;
  wire addr_wr = req.wr && req.sel == SEL_ADDRESS;
  wire data_wr = req.wr && req.sel == SEL_DATA;
  wire abort   = state_reg == EAC_PROG && (addr_wr || data_wr);

  // Address register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_index_field_reg <= '0;
    end else if (addr_wr) begin
      byte_index_field_reg <= req.wdata[ADDR_W-1:0]; // [R01]
    end
  end

  // Data register: CPU write or fetched byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_value_field_reg <= RESET_BYTE;
    end else if (rstart) begin
      byte_value_field_reg <= mem[byte_index_field_reg]; // [R03] [R10]
    end else if (data_wr) begin
      byte_value_field_reg <= req.wdata; // [R03]
    end
  end

  // Arm bit with four-cycle timeout; a strobe write never arms
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      master_write_arm_reg <= 1'b0;
      arm_cnt_reg          <= '0;
    end else if (set_arm) begin
      master_write_arm_reg <= 1'b1; // [R06]
      arm_cnt_reg          <= 3'(ARM_CYCLES - 1);
    end else if (master_write_arm_reg) begin
      if (arm_cnt_reg == 3'h0) begin
        master_write_arm_reg <= 1'b0; // [R04]
      end else begin
        arm_cnt_reg <= arm_cnt_reg - 3'h1;
      end
    end
  end

  // Read strobe is visible only for the stall; the fetch itself is done at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_strobe_reg <= 1'b0;
    end else if (rstart) begin
      read_strobe_reg <= 1'b1;
    end else if (stall_cnt_reg <= 3'h1) begin
      read_strobe_reg <= 1'b0; // [R10]
    end
  end

  // Self-timed programming; the array is written at the end of the interval
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg    <= EAC_IDLE;
      prog_cnt_reg <= '0;
    end else begin
      case (state_reg)
        EAC_IDLE: begin
          if (wstart) begin
            state_reg    <= EAC_PROG; // [R05]
            prog_cnt_reg <= 32'(PROG_TIME - 1);
          end
        end
        EAC_PROG: begin
          if (abort) begin
            state_reg <= EAC_IDLE; // [R12]
          end else if (prog_cnt_reg == 32'h0) begin
            state_reg <= EAC_IDLE; // [R08]
          end else begin
            prog_cnt_reg <= prog_cnt_reg - 32'h1;
          end
        end
        default: state_reg <= EAC_IDLE;
      endcase
    end
  end

  // Array is left untouched on abort, so the stored byte keeps its old value
  always_ff @(posedge ref_clk) begin
    if (state_reg == EAC_PROG && !abort && prog_cnt_reg == 32'h0) begin
      mem[byte_index_field_reg] <= byte_value_field_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      write_strobe_busy <= 1'b0;
    end else begin
      write_strobe_busy <= (state_reg == EAC_IDLE) ? wstart
                           : !(abort || prog_cnt_reg == 32'h0); // [R15]
    end
  end

  // CPU stall counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stall_cnt_reg <= '0;
      cpu_stall     <= 1'b0;
    end else if (wstart) begin
      stall_cnt_reg <= 3'(WSTALL_CYCLES); // [R09]
      cpu_stall     <= 1'b1;
    end else if (rstart) begin
      stall_cnt_reg <= 3'(RSTALL_CYCLES); // [R11]
      cpu_stall     <= 1'b1;
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_reg <= stall_cnt_reg - 3'h1;
      cpu_stall     <= stall_cnt_reg > 3'h1;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    case (req.sel)
      SEL_ADDRESS: rdata_next = {1'b0, byte_index_field_reg}; // [R02]
      SEL_DATA:    rdata_next = byte_value_field_reg;
      SEL_CONTROL: rdata_next = {5'h00, master_write_arm_reg,
                                 write_strobe_busy, read_strobe_reg}; // [R02]
      default:     rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

  chk_arm_timeout: assert property (@(posedge ref_clk) disable iff (rst) // [R04]
    set_arm |=> master_write_arm_reg [*4] ##1 (!master_write_arm_reg || $past(set_arm)))
    else $error("arm bit did not time out after four cycles");

  chk_strobe_gate: assert property (@(posedge ref_clk) disable iff (rst) // [R05]
    (ctl_wr && req.wdata[BIT_WSTROBE] && !master_write_arm_reg && state_reg == EAC_IDLE)
    |=> !write_strobe_busy)
    else $error("write started without arm");

  sequence s_write_stall;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence

  chk_write_stall: assert property (@(posedge ref_clk) disable iff (rst) // [R09]
    wstart |=> s_write_stall)
    else $error("write stall not two cycles");

  // Stall and visible read strobe both start on the edge after the strobe
  chk_read_stall: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    rstart |=> cpu_stall && read_strobe_reg)
    else $error("read stall did not start");

  sequence s_read_stall;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence
  chk_read_stall4: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    rstart |=> s_read_stall)
    else $error("read stall not four cycles");

  chk_read_fetch: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    rstart |=> byte_value_field_reg == $past(mem[byte_index_field_reg]))
    else $error("read did not fetch byte");

  // Checked cycle by cycle, so a legal abort does not trip it
  chk_busy_hold: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
    (state_reg == EAC_PROG && !abort && prog_cnt_reg != 32'h0) |=> write_strobe_busy)
    else $error("busy dropped early");

  chk_abort_ends: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    abort |=> !write_strobe_busy && state_reg == EAC_IDLE)
    else $error("abort did not end programming");

  chk_prog_ends: assert property (@(posedge ref_clk) disable iff (rst) // [R08]
    (state_reg == EAC_PROG && prog_cnt_reg == 32'h0 && !abort) |=> !write_strobe_busy)
    else $error("busy not cleared at end");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    ($past(req.sel) == SEL_CONTROL |-> rdata[7:3] == 5'h00) and
    ($past(req.sel) == SEL_ADDRESS |-> rdata[7] == 1'b0))
    else $error("reserved bits not zero");

  // Further guards on arming, loading, programming and readback

  sequence s_read_strobe_window;
    read_strobe_reg [*4] ##1 !read_strobe_reg;
  endsequence

  chk_arm_refused: assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    (ctl_wr && req.wdata[BIT_ARM] && req.wdata[BIT_WSTROBE] && !master_write_arm_reg)
    |=> !master_write_arm_reg)
    else $error("arm bit set together with the write strobe");

  chk_arm_expiry: assert property (@(posedge ref_clk) disable iff (rst) // [R04]
    set_arm ##1 (!set_arm) [*4] |=> !master_write_arm_reg)
    else $error("arm bit outlived its window");

  chk_arm_count: assert property (@(posedge ref_clk) disable iff (rst) // [R04]
    master_write_arm_reg |-> arm_cnt_reg <= 3'(ARM_CYCLES - 1))
    else $error("arm counter out of range");

  chk_addr_load: assert property (@(posedge ref_clk) disable iff (rst) // [R01]
    addr_wr |=> byte_index_field_reg == $past(req.wdata[ADDR_W-1:0]))
    else $error("address register not loaded");

  chk_data_load: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
    (data_wr && !rstart) |=> byte_value_field_reg == $past(req.wdata))
    else $error("data register not loaded");

  chk_busy_start: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
    wstart |=> write_strobe_busy)
    else $error("busy did not rise after strobe");

  chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst) // [R08]
    (state_reg == EAC_IDLE && !wstart) |=> !write_strobe_busy)
    else $error("busy while idle");

  chk_prog_load: assert property (@(posedge ref_clk) disable iff (rst) // [R08]
    wstart |=> state_reg == EAC_PROG && prog_cnt_reg == 32'(PROG_TIME - 1))
    else $error("programming interval not loaded");

  chk_rstrobe_window: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    rstart |=> s_read_strobe_window)
    else $error("read strobe did not clear after the stall");

  chk_stall_rest: assert property (@(posedge ref_clk) disable iff (rst) // [R09] [R11]
    (!wstart && !rstart && stall_cnt_reg == 3'h0) |=> !cpu_stall)
    else $error("stall without a strobe");

  chk_mem_commit: assert property (@(posedge ref_clk) disable iff (rst) // [R05] [R08]
    (state_reg == EAC_PROG && !abort && prog_cnt_reg == 32'h0)
    |=> mem[$past(byte_index_field_reg)] == $past(byte_value_field_reg))
    else $error("byte not stored at end of programming");

  chk_abort_keeps: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    abort |=> mem[$past(byte_index_field_reg)] == $past(mem[byte_index_field_reg]))
    else $error("aborted write touched the array");

  chk_read_refused: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    (ctl_wr && req.wdata[BIT_RSTROBE] && state_reg == EAC_PROG)
    |=> byte_value_field_reg == $past(byte_value_field_reg))
    else $error("read strobe honoured while busy");

  chk_ctl_readback: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
    $past(req.sel) == SEL_CONTROL |-> rdata[BIT_WSTROBE] == $past(write_strobe_busy))
    else $error("busy not visible in control readback");

  chk_sel3_zero: assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    $past(req.sel) == 2'h3 |-> rdata == 8'h00)
    else $error("unused select did not read zero");
endmodule

// *** eac_top_test.sv ***
// Self-checking testbench for the nonvolatile byte access controller
`timescale 1ns/1ps
module eac_top_test
  import eac_pkg::*;
;
  localparam int PT = 20;
  logic       ref_clk;
  logic       rst;
  eac_req_t   req;
  logic [7:0] rdata;
  logic       cpu_stall;
  logic       write_strobe_busy;
  int         fail_count;
  int         num_checks;

  // Short programming time keeps each write within a few dozen cycles
  eac_top #(.PROG_TIME(PT)) dut_u (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .req               (req),
    .rdata             (rdata),
    .cpu_stall         (cpu_stall),
    .write_strobe_busy (write_strobe_busy)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  // Read data is registered, so it is sampled one edge after the select
  task automatic rd(input logic [1:0] s, output logic [7:0] v);
    @(posedge ref_clk);
    req.sel <= s;
    @(posedge ref_clk);
    #1 v = rdata;
  endtask

  // Counts stall and busy cycles over a span longer than a whole write
  task automatic watch(output int s, output int b);
    s = 0;
    b = 0;
    repeat (PT + 10) begin
      #1;
      if (cpu_stall === 1'b1) s++;
      if (write_strobe_busy === 1'b1) b++;
      @(posedge ref_clk);
    end
  endtask

  task automatic sc_regs();
    logic [7:0] v;
    wr(SEL_ADDRESS, 8'hff);
    rd(SEL_ADDRESS, v);
    chk(v, 8'h7f);
    wr(SEL_CONTROL, 8'hf8);
    rd(SEL_CONTROL, v);
    chk(v, 8'h00);
  endtask

  task automatic sc_read(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    int         s;
    int         b;
    rd(SEL_CONTROL, v);
    chk(v & 8'h02, 8'h00);
    wr(SEL_DATA, 8'h00);
    wr(SEL_ADDRESS, {1'b0, a});
    wr(SEL_CONTROL, 8'h01);
    watch(s, b);
    chk(s[7:0], 8'h04);
    rd(SEL_DATA, v);
    chk(v, exp);
    rd(SEL_CONTROL, v);
    chk(v, 8'h00);
  endtask

  task automatic sc_write(input logic [6:0] a, input logic [7:0] d);
    int s;
    int b;
    wr(SEL_ADDRESS, {1'b0, a});
    wr(SEL_DATA, d);
    wr(SEL_CONTROL, 8'h04);
    wr(SEL_CONTROL, 8'h02);
    watch(s, b);
    chk(s[7:0], 8'h02);
    chk(b[7:0], 8'(PT));
  endtask

  task automatic sc_refuse();
    logic [7:0] v;
    int         s;
    int         b;
    wr(SEL_CONTROL, 8'h02);
    watch(s, b);
    chk(b[7:0], 8'h00);
    wr(SEL_CONTROL, 8'h06);
    watch(s, b);
    chk(b[7:0], 8'h00);
    wr(SEL_CONTROL, 8'h04);
    rd(SEL_CONTROL, v);
    chk(v, 8'h04);
    repeat (4) @(posedge ref_clk);
    rd(SEL_CONTROL, v);
    chk(v, 8'h00);
    wr(SEL_CONTROL, 8'h02);
    watch(s, b);
    chk(b[7:0], 8'h00);
  endtask

  // A data write in mid-programming must end the busy interval early
  task automatic sc_abort();
    logic [7:0] v;
    wr(SEL_ADDRESS, 8'h03);
    wr(SEL_DATA, 8'h11);
    wr(SEL_CONTROL, 8'h04);
    wr(SEL_CONTROL, 8'h02);
    repeat (5) @(posedge ref_clk);
    wr(SEL_DATA, 8'h22);
    repeat (3) @(posedge ref_clk);
    #1 chk({7'h00, write_strobe_busy}, 8'h00);
    rd(SEL_DATA, v);
    chk(v, 8'h22);
  endtask

  initial begin
    #100000;
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    num_checks = 0;
    rst = 1'b1;
    req = '{wr: 1'b0, rd: 1'b0, sel: 2'h0, wdata: 8'h00};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    sc_regs();
    sc_write(7'h00, 8'h5a);
    sc_write(7'h7f, 8'ha5);
    sc_read(7'h7f, 8'ha5);
    sc_read(7'h00, 8'h5a);
    sc_refuse();
    sc_read(7'h7f, 8'ha5);
    sc_abort();
    conclude();
  end
endmodule
